// ### common/lps_pkg.sv
// Constants, commands and states of the DDR3 low-power sequencer.
package lps_pkg;

  // ***********************************************************************
  // Clock and timing figures.
  // ***********************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CKE_NS = 100;
  localparam int T_CKESR_NS = 150;
  localparam int T_CKSRE_NS = 100;
  localparam int T_CKSRX_NS = 100;
  localparam int T_XS_NS = 300;
  localparam int T_XSDLL_NCK = 512;
  localparam int T_XP_NS = 100;
  localparam int T_XPDLL_NS = 600;
  localparam int T_RFC_NS = 300;
  localparam int T_REFI_NS = 7800;
  localparam int T_CPDED_NCK = 1;
  localparam int T_ODTL_NCK = 5;
  localparam int T_WR_AFTER_SRX_NCK = 512;
  localparam int PD_MAX_REFI = 9;
  localparam int MAX_POSTPONED = 8;

  // Least time in whole cycles, rounded up and never below one.
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int C_CKE = cyc_up(T_CKE_NS);
  localparam int C_SR_MIN = imax(cyc_up(T_CKESR_NS), cyc_up(T_CKSRE_NS));
  localparam int C_CKSRX = cyc_up(T_CKSRX_NS);
  localparam int C_XS = cyc_up(T_XS_NS);
  localparam int C_XSDLL_REST = imax(T_XSDLL_NCK - C_XS, 1);
  localparam int C_XP = imax(cyc_up(T_XP_NS), C_CKE);
  localparam int C_XPDLL_REST = imax(cyc_up(T_XPDLL_NS) - C_XP, 1);
  localparam int C_RFC = cyc_up(T_RFC_NS);
  localparam int C_ODT_OFF = T_ODTL_NCK + 1;
  localparam int C_CPDED = T_CPDED_NCK;
  localparam int C_WR_BLOCK = T_WR_AFTER_SRX_NCK;
  // Longest power-down residency, rounded down.
  localparam int C_PD_MAX = imax((PD_MAX_REFI * T_REFI_NS) / CLK_PERIOD_NS, 1);
  // Remaining count at which the least power-down time has passed.
  localparam int C_PD_MIN_REM = C_PD_MAX - C_CKE;

  // ***********************************************************************
  // Commands as {cs_n, ras_n, cas_n, we_n}.
  // ***********************************************************************
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REF_SRE = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;

  typedef enum logic [3:0] {
    ST_IDLE, ST_REF, ST_ODT_WAIT, ST_SR, ST_SRX_CLK, ST_XS, ST_XSDLL,
    ST_PDE, ST_PD, ST_XP, ST_XPDLL, ST_RESET
  } lps_state_t;

endpackage

// ### test/lps_ctrl_properties.sv
// Concurrent checks on the pins of the low-power sequencer.
module lps_ctrl_checker
  import lps_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic want_reset,
  input wire logic cke_q,
  input wire logic cs_n_q,
  input wire logic ras_n_q,
  input wire logic cas_n_q,
  input wire logic we_n_q,
  input wire logic odt_q,
  input wire logic reset_n_q,
  input wire logic in_sr_q,
  input wire logic in_pd_q
);
  // ****
  // Helper counters.
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] cmd;
  logic ckep_q, srp_q;
  int since_q, since_d, pd_q, pd_d;
  assign cmd = {cs_n_q, ras_n_q, cas_n_q, we_n_q};
  // Cycles since the last self-refresh exit, and cycles with CKE low in power-down.
  always_comb begin
    since_d = (since_q < 4095) ? since_q + 1 : since_q;
    if (cke_q && !ckep_q && srp_q) since_d = 1;
    pd_d = (in_pd_q && !cke_q) ? pd_q + 1 : 0;
  end
  // Registers of the helper counters.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      since_q <= 4095;
      pd_q <= 0;
      ckep_q <= 1'b1;
      srp_q <= 1'b0;
    end else begin
      since_q <= since_d;
      pd_q <= pd_d;
      ckep_q <= cke_q;
      srp_q <= in_sr_q;
    end
  end
  // ****
  // Properties.
  // ****
  sequence s_sre; $fell(cke_q) && cmd == CMD_REF_SRE; endsequence
  sequence s_srx; $rose(cke_q) && $past(in_sr_q) && $past(reset_n_q); endsequence
  sequence s_pde; $fell(cke_q) && cmd == CMD_NOP && reset_n_q; endsequence
  sequence s_pdx; $rose(cke_q) && $past(in_pd_q) && $past(reset_n_q); endsequence
  property p_sre_odt; s_sre |-> !$past(odt_q, 6) && !$past(odt_q, 1); endproperty
  property p_sr_hold; s_sre |-> (!cke_q && in_sr_q) [*3]; endproperty
  property p_xs_nop; s_srx |-> (cke_q && !odt_q && cmd == CMD_NOP) [*6]; endproperty
  property p_wr_block; cke_q && cmd == CMD_WRITE |-> since_q >= C_WR_BLOCK; endproperty
  property p_pde_nop; s_pde |-> (!cke_q && cmd == CMD_NOP) [*2]; endproperty
  property p_pd_max; pd_q < C_PD_MAX; endproperty
  property p_pdx; s_pdx |-> (cke_q && cmd == CMD_NOP) [*2]; endproperty
  property p_reset; want_reset |=> !reset_n_q && !cke_q; endproperty
  a_sre_odt: assert property (p_sre_odt) else $error("ODT high before SR entry.");
  a_sr_hold: assert property (p_sr_hold) else $error("SR left too soon.");
  a_xs_nop: assert property (p_xs_nop) else $error("Non-NOP in SR exit.");
  a_wr_block: assert property (p_wr_block) else $error("Write too soon.");
  a_pde_nop: assert property (p_pde_nop) else $error("Bad PD entry.");
  a_pd_max: assert property (p_pd_max) else $error("PD too long.");
  a_pdx: assert property (p_pdx) else $error("Bad PD exit.");
  a_reset: assert property (p_reset) else $error("Reset not driven.");
endmodule
bind lps_ctrl lps_ctrl_checker lps_ctrl_checker_inst (.clk, .nrst, .want_reset, .cke_q,
  .cs_n_q, .ras_n_q, .cas_n_q, .we_n_q, .odt_q, .reset_n_q, .in_sr_q, .in_pd_q);

// ### test/lps_dev_model.sv
// Behavioural DDR3 device: low-power state, DLL state and internal refresh.
module lps_dev_model
  import lps_pkg::*;
(
  input wire logic clk,
  input wire logic cke_q,
  input wire logic cs_n_q,
  input wire logic ras_n_q,
  input wire logic cas_n_q,
  input wire logic we_n_q,
  input wire logic odt_q,
  input wire logic reset_n_q,
  input wire logic banks_open,
  input wire logic mr0_a12,
  output logic [2:0] st_q,
  output logic dll_off_q,
  output logic [7:0] nref_q,
  output logic bad_q
);
  logic ckep_q;
  logic [3:0] cmd;
  assign cmd = {cs_n_q, ras_n_q, cas_n_q, we_n_q};
  // Power-up values of the model.
  initial begin
    st_q = 3'h4;
    dll_off_q = 1'b0;
    nref_q = 8'h0;
    bad_q = 1'b0;
    ckep_q = 1'b1;
  end
  // States 0 idle, 1 self-refresh, 2 active and 3 precharge power-down, 4 reset.
  // Inputs other than CKE and RESET are ignored in a low-power state.
  always @(posedge clk) begin
    ckep_q <= cke_q;
    if (!reset_n_q) begin
      st_q <= 3'h4;
    end else if (st_q == 3'h4) begin
      st_q <= 3'h0;
    end else if (st_q == 3'h0 && ckep_q && !cke_q) begin
      if (cmd == CMD_REF_SRE) begin
        st_q <= 3'h1;
        dll_off_q <= 1'b1;
        nref_q <= nref_q + 8'h1;
        bad_q <= bad_q | odt_q;
      end else begin
        st_q <= banks_open ? 3'h2 : 3'h3;
        dll_off_q <= !banks_open && !mr0_a12;
        bad_q <= bad_q | (cmd != CMD_NOP);
      end
    end else if (st_q != 3'h0 && cke_q) begin
      st_q <= 3'h0;
      dll_off_q <= 1'b0;
      bad_q <= bad_q | (cmd != CMD_NOP);
    end
  end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the low-power sequencer.
module tb_top import lps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, want_sr, want_pd, want_reset, dev_idle, banks_open, cke_hold;
  logic dll_locked, mr0_a12, user_odt, cke_q, cs_n_q, ras_n_q, cas_n_q, we_n_q, odt_q;
  logic reset_n_q, cmd_ok_q, dll_cmd_ok_q, wr_ok_q, clk_stop_ok_q, in_sr_q, in_pd_q;
  logic pd_active_q, slow_exit_q, need_dll_reset_q, need_ref_q, dll_off_q, bad_q;
  logic [3:0] ref_postponed, user_cmd, pins;
  logic [2:0] st_q;
  logic [7:0] nref_q;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  assign pins = {cs_n_q, ras_n_q, cas_n_q, we_n_q};
  lps_ctrl lps_ctrl_inst (.clk, .nrst, .want_sr, .want_pd, .want_reset, .dev_idle,
    .banks_open, .cke_hold, .dll_locked, .mr0_a12, .ref_postponed, .user_cmd, .user_odt,
    .cke_q, .cs_n_q, .ras_n_q, .cas_n_q, .we_n_q, .odt_q, .reset_n_q, .cmd_ok_q,
    .dll_cmd_ok_q, .wr_ok_q, .clk_stop_ok_q, .in_sr_q, .in_pd_q, .pd_active_q,
    .slow_exit_q, .need_dll_reset_q, .need_ref_q);
  lps_dev_model lps_dev_model_inst (.clk, .cke_q, .cs_n_q, .ras_n_q, .cas_n_q, .we_n_q,
    .odt_q, .reset_n_q, .banks_open, .mr0_a12, .st_q, .dll_off_q, .nref_q, .bad_q);
  // Clock of 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Cycle ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return cke_q;
      1: return dll_cmd_ok_q;
      default: return pins === CMD_REF_SRE;
    endcase
  endfunction
  // Waits, bounded, for a watched signal to reach a level.
  task automatic wait_on(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      step();
      n++;
    end
    // A wait that runs out counts as a mismatch.
    chk(sig(s), v);
  endtask
  task automatic t_rst();
    chk(cke_q, 1);
    chk(pins, CMD_NOP);
    chk(reset_n_q, 1);
    user_cmd = 4'h3;
    step();
    chk(pins, 4'h3);
    user_cmd = CMD_NOP;
    {want_pd, cke_hold} = 2'h3;
    step(4);
    chk(cke_q, 1);
    {want_pd, cke_hold, want_sr, ref_postponed} = {3'h1, 4'h9};
    step(10);
    chk(cke_q, 1);
    {ref_postponed, dev_idle} = {4'h8, 1'b0};
    step(10);
    chk(cke_q, 1);
    {want_sr, dev_idle} = 2'h1;
    step(2);
    chk(st_q, 0);
    $display("t_rst done");
  endtask
  task automatic t_sr();
    int n;
    user_odt = 1'b1;
    want_sr = 1'b1;
    step();
    chk(odt_q, 0);
    wait_on(0, 0, 20, n);
    chk(n, C_ODT_OFF + 1);
    chk(pins, CMD_REF_SRE);
    step(4);
    chk(st_q, 1);
    chk(in_sr_q, 1);
    chk(nref_q, 1);
    chk(clk_stop_ok_q, 1);
    want_sr = 1'b0;
    step();
    chk(clk_stop_ok_q, 0);
    wait_on(0, 1, 10, n);
    chk(n, C_CKSRX + 1);
    chk(need_ref_q, 1);
    chk(in_sr_q, 0);
    user_cmd = CMD_WRITE;
    step(C_XS + 2);
    chk(pins, CMD_NOP);
    chk(cmd_ok_q, 1);
    user_cmd = CMD_READ;
    step(2);
    chk(pins, CMD_NOP);
    {user_cmd, want_sr} = {CMD_NOP, 1'b1};
    wait_on(2, 1, 20, n);
    chk(cke_q, 1);
    wait_on(0, 0, 30, n);
    chk(pins, CMD_REF_SRE);
    {want_sr, user_odt} = 2'h0;
    wait_on(0, 1, 20, n);
    wait_on(1, 1, 600, n);
    // Two state changes and the status register add three cycles.
    chk(n, T_XSDLL_NCK + 3);
    chk(wr_ok_q, 1);
    user_cmd = CMD_WRITE;
    step();
    chk(pins, CMD_WRITE);
    user_cmd = CMD_NOP;
    $display("t_sr done");
  endtask
  // Entry from idle with a refresh owed issues that refresh first.
  task automatic t_srref();
    int n;
    step();
    want_sr = 1'b1;
    step();
    chk(pins, CMD_REF_SRE);
    chk(need_ref_q, 0);
    wait_on(0, 0, 30, n);
    chk(n, C_RFC + C_ODT_OFF + 2);
    chk(pins, CMD_REF_SRE);
    want_sr = 1'b0;
    wait_on(0, 1, 20, n);
    chk(need_ref_q, 1);
    wait_on(1, 1, 600, n);
    $display("t_srref done");
  endtask
  task automatic t_pd();
    int n;
    logic slow;
    for (int i = 0; i < 4; i++) begin
      {mr0_a12, banks_open, dll_locked} = {i[1], i[0], ~i[0]};
      slow = !banks_open && !mr0_a12;
      want_pd = 1'b1;
      step();
      chk(cke_q, 0);
      chk(pd_active_q, banks_open);
      chk(slow_exit_q, slow);
      chk(need_dll_reset_q, !dll_locked);
      chk(in_pd_q, 1);
      step(3);
      chk(st_q, banks_open ? 3'h2 : 3'h3);
      chk(dll_off_q, slow);
      want_pd = 1'b0;
      wait_on(0, 1, 10, n);
      chk(in_pd_q, 0);
      step(C_XP + 2);
      chk(cmd_ok_q, 1);
      chk(dll_cmd_ok_q, !slow);
      wait_on(1, 1, 30, n);
    end
    chk(bad_q, 0);
    {banks_open, dll_locked} = 2'h1;
    $display("t_pd done");
  endtask
  task automatic t_pdmax();
    int n;
    want_pd = 1'b1;
    wait_on(0, 0, 5, n);
    wait_on(0, 1, 1500, n);
    chk(n > C_CKE && n <= C_PD_MAX, 1);
    wait_on(0, 0, 10, n);
    step(2);
    want_reset = 1'b1;
    step();
    chk(reset_n_q, 0);
    step();
    chk(st_q, 4);
    {want_reset, want_pd} = 2'h0;
    wait_on(0, 1, 10, n);
    chk(reset_n_q, 1);
    step(2);
    chk(st_q, 0);
    $display("t_pdmax done");
  endtask
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {nrst, want_sr, want_pd, want_reset, banks_open, cke_hold, mr0_a12, user_odt} = '0;
    {dev_idle, dll_locked, ref_postponed, user_cmd} = {2'h3, 4'h0, CMD_NOP};
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    t_rst();
    t_sr();
    t_srref();
    t_pd();
    t_pdmax();
    end_of_test();
  end
endmodule

// ### verilog/lps_ctrl.sv
// Controller that sequences DDR3 self-refresh and power-down over the pins.
module lps_ctrl
  import lps_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic want_sr,
  input wire logic want_pd,
  input wire logic want_reset,
  input wire logic dev_idle,
  input wire logic banks_open,
  input wire logic cke_hold,
  input wire logic dll_locked,
  input wire logic mr0_a12,
  input wire logic [3:0] ref_postponed,
  input wire logic [3:0] user_cmd,
  input wire logic user_odt,
  output logic cke_q,
  output logic cs_n_q,
  output logic ras_n_q,
  output logic cas_n_q,
  output logic we_n_q,
  output logic odt_q,
  output logic reset_n_q,
  output logic cmd_ok_q,
  output logic dll_cmd_ok_q,
  output logic wr_ok_q,
  output logic clk_stop_ok_q,
  output logic in_sr_q,
  output logic in_pd_q,
  output logic pd_active_q,
  output logic slow_exit_q,
  output logic need_dll_reset_q,
  output logic need_ref_q
);

  // ***********************************************************************
  // Elaboration checks.
  // ***********************************************************************
  generate
    if (TW < $clog2(C_PD_MAX + 1) || TW < $clog2(C_WR_BLOCK + 1)) begin : g_bad_tw
      $error("lps_ctrl timer width cannot hold the longest wait");
    end
  endgenerate

  // Commands that depend on a locked DLL or on a settled write path.
  function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] k);
    return c == k;
  endfunction

  // ***********************************************************************
  // State and timers.
  // ***********************************************************************
  lps_state_t state_q, state_d;
  logic t_load, t_done, w_load, w_done;
  logic [TW-1:0] t_val, t_rem;
  logic cke_d, odt_d, reset_n_d;
  logic [3:0] cmd_d, pin_cmd;
  logic cmd_ok_d, dll_cmd_ok_d, wr_ok_d, clk_stop_ok_d;
  logic in_sr_d, in_pd_d, pd_active_d, slow_exit_d, need_dll_reset_d, need_ref_d;
  logic sr_allowed, pd_allowed, pass_cmd, pass_dll, pass_odt;

  lps_timer #(.W(TW)) u_wait (
    .clk(clk),
    .nrst(nrst),
    .load(t_load),
    .val(t_val),
    .rem_q(t_rem),
    .done(t_done)
  );

  // Counts the write blackout that follows a self-refresh exit.
  lps_timer #(.W(TW)) u_wrblk (
    .clk(clk),
    .nrst(nrst),
    .load(w_load),
    .val(TW'(C_WR_BLOCK)),
    .rem_q(),
    .done(w_done)
  );

  // Entry qualifiers seen by the sequencer.
  always_comb begin
    sr_allowed = dev_idle && !banks_open && !cke_hold && cke_q;
    sr_allowed = sr_allowed && (ref_postponed <= 4'(MAX_POSTPONED));
    pd_allowed = !cke_hold;
  end

  // ***********************************************************************
  // Sequencer next state and pin values.
  // ***********************************************************************
  always_comb begin
    state_d = state_q;
    t_load = 1'b0;
    t_val = '0;
    w_load = 1'b0;
    cke_d = cke_q;
    pass_cmd = 1'b0;
    pass_dll = 1'b0;
    pass_odt = 1'b0;
    cmd_d = CMD_NOP;
    reset_n_d = 1'b1;
    slow_exit_d = slow_exit_q;
    pd_active_d = pd_active_q;
    need_dll_reset_d = need_dll_reset_q;
    need_ref_d = need_ref_q;
    clk_stop_ok_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        cke_d = 1'b1;
        pass_cmd = 1'b1;
        pass_dll = 1'b1;
        pass_odt = 1'b1;
        if (want_sr && sr_allowed) begin
          pass_cmd = 1'b0;
          pass_odt = 1'b0;
          if (need_ref_q) begin
            state_d = ST_REF;
            cmd_d = CMD_REF_SRE;
            need_ref_d = 1'b0;
            t_load = 1'b1;
            t_val = TW'(C_RFC);
          end else begin
            state_d = ST_ODT_WAIT;
            t_load = 1'b1;
            t_val = TW'(C_ODT_OFF);
          end
        end else if (want_pd && pd_allowed) begin
          // CKE falls with a NOP and the power-down flavour is fixed here.
          state_d = ST_PDE;
          pass_cmd = 1'b0;
          cke_d = 1'b0;
          pd_active_d = banks_open;
          slow_exit_d = !banks_open && !mr0_a12;
          need_dll_reset_d = !dll_locked;
          t_load = 1'b1;
          t_val = TW'(C_CPDED);
        end
      end
      ST_REF: begin
        cke_d = 1'b1;
        if (t_done) begin
          state_d = ST_ODT_WAIT;
          t_load = 1'b1;
          t_val = TW'(C_ODT_OFF);
        end
      end
      ST_ODT_WAIT: begin
        // ODT is already low; the entry command follows after ODTL plus one.
        if (t_done) begin
          state_d = ST_SR;
          cmd_d = CMD_REF_SRE;
          cke_d = 1'b0;
          t_load = 1'b1;
          t_val = TW'(C_SR_MIN);
        end
      end
      ST_SR: begin
        cke_d = 1'b0;
        clk_stop_ok_d = t_done;
        if (t_done && !want_sr) begin
          state_d = ST_SRX_CLK;
          clk_stop_ok_d = 1'b0;
          t_load = 1'b1;
          t_val = TW'(C_CKSRX);
        end
      end
      ST_SRX_CLK: begin
        // The clock must run stable for tCKSRX before CKE rises.
        cke_d = 1'b0;
        if (t_done) begin
          state_d = ST_XS;
          cke_d = 1'b1;
          need_ref_d = 1'b1;
          w_load = 1'b1;
          t_load = 1'b1;
          t_val = TW'(C_XS);
        end
      end
      ST_XS: begin
        cke_d = 1'b1;
        if (t_done) begin
          state_d = ST_XSDLL;
          t_load = 1'b1;
          t_val = TW'(C_XSDLL_REST);
        end
      end
      ST_XSDLL: begin
        cke_d = 1'b1;
        pass_cmd = 1'b1;
        if (want_sr && sr_allowed) begin
          // Early re-entry is allowed once a refresh has been given.
          state_d = ST_REF;
          pass_cmd = 1'b0;
          cmd_d = CMD_REF_SRE;
          need_ref_d = 1'b0;
          t_load = 1'b1;
          t_val = TW'(C_RFC);
        end else if (t_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_PDE: begin
        cke_d = 1'b0;
        pass_odt = 1'b1;
        if (t_done) begin
          state_d = ST_PD;
          t_load = 1'b1;
          t_val = TW'(C_PD_MAX - C_CPDED - 3); // CKE-low time ends below nine tREFI.
        end
      end
      ST_PD: begin
        cke_d = 1'b0;
        pass_odt = 1'b1;
        // Leave on request once tCKE passed, or when nine tREFI run out.
        if ((!want_pd && t_rem <= TW'(C_PD_MIN_REM - C_CPDED - 3)) || t_done) begin
          state_d = ST_XP;
          cke_d = 1'b1;
          t_load = 1'b1;
          t_val = TW'(C_XP);
        end
      end
      ST_XP: begin
        cke_d = 1'b1;
        pass_odt = 1'b1;
        if (t_done) begin
          if (slow_exit_q) begin
            state_d = ST_XPDLL;
            t_load = 1'b1;
            t_val = TW'(C_XPDLL_REST);
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_XPDLL: begin
        cke_d = 1'b1;
        pass_cmd = 1'b1;
        if (t_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_RESET: begin
        cke_d = 1'b0;
        reset_n_d = 1'b0;
        need_ref_d = 1'b0;
        if (!want_reset) begin
          state_d = ST_IDLE;
          reset_n_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (want_reset) begin
      // Reset is honoured from any state, power-down included.
      state_d = ST_RESET;
      reset_n_d = 1'b0;
      cke_d = 1'b0;
      pass_cmd = 1'b0;
      pass_odt = 1'b0;
      cmd_d = CMD_NOP;
      t_load = 1'b0;
    end
  end

  // ***********************************************************************
  // Command gating and status.
  // ***********************************************************************
  always_comb begin
    wr_ok_d = w_done && (state_d == ST_IDLE || state_d == ST_XSDLL ||
                         state_d == ST_XPDLL);
    cmd_ok_d = pass_cmd;
    dll_cmd_ok_d = pass_cmd && pass_dll;
    odt_d = pass_odt ? user_odt : 1'b0;
    pin_cmd = cmd_d;
    if (pass_cmd) begin
      pin_cmd = user_cmd;
      if (is_cmd(user_cmd, CMD_READ) && !pass_dll) begin
        pin_cmd = CMD_NOP;
      end
      if (is_cmd(user_cmd, CMD_WRITE) && !w_done) begin
        pin_cmd = CMD_NOP;
      end
    end
    in_sr_d = (state_d == ST_SR || state_d == ST_SRX_CLK);
    in_pd_d = (state_d == ST_PDE || state_d == ST_PD);
  end

  // Registers every pin and status output.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cke_q <= 1'b1;
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= CMD_NOP;
      odt_q <= 1'b0;
      reset_n_q <= 1'b1;
      cmd_ok_q <= 1'b0;
      dll_cmd_ok_q <= 1'b0;
      wr_ok_q <= 1'b0;
      clk_stop_ok_q <= 1'b0;
      in_sr_q <= 1'b0;
      in_pd_q <= 1'b0;
      pd_active_q <= 1'b0;
      slow_exit_q <= 1'b0;
      need_dll_reset_q <= 1'b0;
      need_ref_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cke_q <= cke_d;
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= pin_cmd;
      odt_q <= odt_d;
      reset_n_q <= reset_n_d;
      cmd_ok_q <= cmd_ok_d;
      dll_cmd_ok_q <= dll_cmd_ok_d;
      wr_ok_q <= wr_ok_d;
      clk_stop_ok_q <= clk_stop_ok_d;
      in_sr_q <= in_sr_d;
      in_pd_q <= in_pd_d;
      pd_active_q <= pd_active_d;
      slow_exit_q <= slow_exit_d;
      need_dll_reset_q <= need_dll_reset_d;
      need_ref_q <= need_ref_d;
    end
  end

endmodule

// ### verilog/lps_timer.sv
// Loadable down counter used for every wait of the sequencer.
module lps_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] val,
  output logic [W-1:0] rem_q,
  output logic done
);

  logic [W-1:0] rem_d;

  generate
    if (W < 2) begin : g_bad_width
      $error("lps_timer width too small");
    end
  endgenerate

  // A load wins; otherwise count down and rest at zero.
  always_comb begin
    rem_d = rem_q;
    if (load) begin
      rem_d = val;
    end else if (rem_q != '0) begin
      rem_d = rem_q - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rem_q <= '0;
    end else begin
      rem_q <= rem_d;
    end
  end

  assign done = (rem_q == '0);

endmodule
